// *** uteo_pkg.sv ***
// Shared constants and types for the UART task, subscription and event block
package uteo_pkg;
	// Clock and serial timing
	localparam int CLK_HZ = 25_000_000;
	localparam int BAUD_HZ = 115_200;
	// Bit period in cycles, rounded down
	localparam int BAUD_DIV = CLK_HZ / BAUD_HZ;
	localparam int HALF_DIV = BAUD_DIV / 2;
	localparam logic [15:0] BIT_CYC = 16'(BAUD_DIV - 1);
	localparam logic [15:0] HALF_CYC = 16'(HALF_DIV - 1);

	// Task indices
	localparam int T_RXSTART = 0;
	localparam int T_RXSTOP = 1;
	localparam int T_TXSTART = 2;
	localparam int T_TXSTOP = 3;
	localparam int T_FLUSH = 4;
	localparam int N_TASK = 5;

	// Event indices
	localparam int E_CTS = 0;
	localparam int E_NCTS = 1;
	localparam int E_RXRDY = 2;
	localparam int E_ENDRX = 3;
	localparam int E_TXRDY = 4;
	localparam int E_ENDTX = 5;
	localparam int E_ERROR = 6;
	localparam int E_RXTO = 7;
	localparam int N_EVT = 8;

	// Register offsets
	localparam logic [11:0] TASK_OFF [N_TASK] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h02c};
	localparam logic [11:0] SUB_OFF [N_TASK] = '{12'h080, 12'h084, 12'h088, 12'h08c, 12'h0ac};
	localparam logic [11:0] EVT_OFF [N_EVT] = '{12'h100, 12'h104, 12'h108, 12'h110,
		12'h11c, 12'h120, 12'h124, 12'h144};
	localparam logic [11:0] STATUS_OFF = 12'h400;
	localparam logic [11:0] RXMAX_OFF = 12'h538;
	localparam logic [11:0] TXMAX_OFF = 12'h548;

	// Field positions and reset values
	localparam int TRIG_BIT = 0;
	localparam int FLAG_BIT = 0;
	localparam int SUB_EN_BIT = 31;
	localparam logic [31:0] SUB_RESET = 32'h0000_0000;
	localparam logic [15:0] MAX_RESET = 16'h0000;

	// Receive FIFO shape
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
	localparam int RTS_SLACK = 2;

	// Subscription register layout
	typedef struct packed {
		logic en;
		logic [22:0] rsvd;
		logic [7:0] channel_index;
	} uteo_sub_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h2,
		RX_STOP = 3'h3,
		RX_BREAK = 3'h4,
		RX_HOLD = 3'h5
	} uteo_rx_st_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_START = 2'h1,
		TX_DATA = 2'h2,
		TX_STOP = 2'h3
	} uteo_tx_st_t;
endpackage : uteo_pkg

// *** uteo_top.sv ***
// Receive FIFO and the UART task, subscription and event block with its APB slave
`timescale 1ns/100ps
// What this block does
// - A 1 written to the flush trigger drains the bytes left in the receive FIFO into the receive buffer.
// - Each of the five tasks has a subscription register whose channel index picks one of 256 channels.
// - The top bit of a subscription register enables the selected channel; when 0 the channel is ignored.
// - The clear-to-send-on flag is set when the incoming clear-to-send line goes low.
// - The clear-to-send-off flag is set when the incoming clear-to-send line goes high.
// - The byte-received flag is set as soon as a byte is received, before it reaches memory.
// - The receive-buffer-full flag is set when the receive buffer has been completely filled.
// - The transmit-end flag is set once the last byte of the transmit buffer has left the line.
// - Each event register reads 1 in bit 0 when its event happened, is writable and resets to 0.
// - A missing stop bit raises the error flag as a framing error.
// - A line held low longer than a frame raises the error flag again as a break, after the framing error.
// - Errors never halt reception; a byte with a bad stop bit is dropped and later bytes are kept.

module uteo_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign level = wr_q - rd_q;
	assign in_ready = (level != (AW+1)'(DEPTH));
	assign out_valid = (wr_q != rd_q);
	assign out_data = mem[rd_q[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage is not reset, only the pointers are
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	// Pointer update
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule : uteo_fifo

module uteo_top
	import uteo_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [255:0] chan_pulse,
	input wire logic rxd,
	input wire logic cts_n,
	output logic txd,
	output logic rts_n,
	output logic rx_mem_valid,
	input wire logic rx_mem_ready,
	output logic [7:0] rx_mem_data,
	input wire logic tx_mem_valid,
	output logic tx_mem_ready,
	input wire logic [7:0] tx_mem_data
);
	logic pready_q, pslverr_q, apb_wr;
	logic [31:0] prdata_q, rd_d;
	logic err_d;
	uteo_sub_t sub_q [N_TASK];
	logic [N_TASK-1:0] task_go;
	logic [N_EVT-1:0] evt_q, evt_set;
	logic [15:0] rx_max_q, tx_max_q, rx_amt_q, tx_amt_q;
	logic rxd_s1, rxd_s2, cts_s1, cts_s2, cts_s3;
	logic rx_on_q, tx_on_q, flush_q, rxto_pend_q;
	uteo_rx_st_t rx_st_q;
	uteo_tx_st_t tx_st_q;
	logic [15:0] rx_cnt_q, tx_cnt_q;
	logic [2:0] rx_bit_q, tx_bit_q;
	logic [7:0] rx_sh_q, tx_sh_q;
	logic rx_ok_q, rx_ferr_q, rx_brk_q, tx_sent_q, tx_end_q;
	logic txd_q, rts_n_q, mem_valid_q, tx_ready_q;
	logic [7:0] mem_data_q;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready, drain_en, tx_take;
	logic [7:0] fifo_out_data;
	logic [$clog2(FIFO_D):0] fifo_level;

	// Decode of a write that completes this cycle at one address
	function automatic logic wr_at(input logic [11:0] a, input logic [11:0] off, input logic done);
		wr_at = done && (a == off);
	endfunction : wr_at

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign txd = txd_q;
	assign rts_n = rts_n_q;
	assign rx_mem_valid = mem_valid_q;
	assign rx_mem_data = mem_data_q;
	assign tx_mem_ready = tx_ready_q;

	// One wait state; the access takes effect on the edge where pready is seen high
	assign apb_wr = psel & penable & pready_q & pwrite;

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & err_d;
			prdata_q <= (psel & penable & ~pready_q & ~pwrite) ? rd_d : 32'h0000_0000;
		end
	end

	// Read mux; unmapped addresses answer with an error and zero data
	always_comb
	begin
		rd_d = 32'h0000_0000;
		err_d = 1'b1;
		for (int i = 0; i < N_TASK; i++)
		begin
			if (paddr == TASK_OFF[i])
				err_d = 1'b0;
			if (paddr == SUB_OFF[i])
			begin
				rd_d = sub_q[i];
				err_d = 1'b0;
			end
		end
		for (int i = 0; i < N_EVT; i++)
		begin
			if (paddr == EVT_OFF[i])
			begin
				rd_d[FLAG_BIT] = evt_q[i];
				err_d = 1'b0;
			end
		end
		if (paddr == RXMAX_OFF)
		begin
			rd_d[15:0] = rx_max_q;
			err_d = 1'b0;
		end
		if (paddr == TXMAX_OFF)
		begin
			rd_d[15:0] = tx_max_q;
			err_d = 1'b0;
		end
		if (paddr == STATUS_OFF)
		begin
			rd_d[8:0] = {fifo_level, 1'b0, flush_q, tx_on_q, rx_on_q};
			err_d = 1'b0;
		end
	end

	// Tasks, subscriptions and event flags, one per generate instance
	genvar gi;
	generate
		for (gi = 0; gi < N_TASK; gi++)
		begin : g_task
			// Only a 1 triggers; a 0 written to a trigger is ignored
			assign task_go[gi] = (wr_at(paddr, TASK_OFF[gi], apb_wr) & pwdata[TRIG_BIT])
				| (sub_q[gi].en & chan_pulse[sub_q[gi].channel_index]);

			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
					sub_q[gi] <= SUB_RESET;
				else if (wr_at(paddr, SUB_OFF[gi], apb_wr))
					sub_q[gi] <= {pwdata[SUB_EN_BIT], 23'h000000, pwdata[7:0]};
			end
		end
		for (gi = 0; gi < N_EVT; gi++)
		begin : g_evt
			// Hardware set wins over a software write in the same cycle
			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
					evt_q[gi] <= 1'b0;
				else if (evt_set[gi])
					evt_q[gi] <= 1'b1;
				else if (wr_at(paddr, EVT_OFF[gi], apb_wr))
					evt_q[gi] <= pwdata[FLAG_BIT];
			end
		end
	endgenerate

	// Event sources
	assign evt_set[E_CTS] = cts_s3 & ~cts_s2;
	assign evt_set[E_NCTS] = ~cts_s3 & cts_s2;
	assign evt_set[E_RXRDY] = rx_ok_q;
	assign evt_set[E_ENDRX] = fifo_out_ready & fifo_out_valid & (rx_amt_q + 16'h0001 == rx_max_q);
	assign evt_set[E_TXRDY] = tx_sent_q;
	assign evt_set[E_ENDTX] = tx_end_q;
	assign evt_set[E_ERROR] = rx_ferr_q | rx_brk_q;
	assign evt_set[E_RXTO] = rxto_pend_q & (rx_st_q == RX_IDLE);

	// Buffer lengths
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			rx_max_q <= MAX_RESET;
			tx_max_q <= MAX_RESET;
		end
		else
		begin
			if (wr_at(paddr, RXMAX_OFF, apb_wr))
				rx_max_q <= pwdata[15:0];
			if (wr_at(paddr, TXMAX_OFF, apb_wr))
				tx_max_q <= pwdata[15:0];
		end
	end

	// Pin synchronisers; cts_s3 is only an edge reference
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
			cts_s1 <= 1'b1;
			cts_s2 <= 1'b1;
			cts_s3 <= 1'b1;
		end
		else
		begin
			rxd_s1 <= rxd;
			rxd_s2 <= rxd_s1;
			cts_s1 <= cts_n;
			cts_s2 <= cts_s1;
			cts_s3 <= cts_s2;
		end
	end

	// Receiver run state, flush and timeout bookkeeping
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			rx_on_q <= 1'b0;
			flush_q <= 1'b0;
			rxto_pend_q <= 1'b0;
			rx_amt_q <= 16'h0000;
		end
		else
		begin
			if (task_go[T_RXSTART])
			begin
				rx_on_q <= 1'b1;
				rx_amt_q <= 16'h0000;
			end
			else if (fifo_out_ready & fifo_out_valid)
				rx_amt_q <= rx_amt_q + 16'h0001;
			if (task_go[T_RXSTOP])
				rx_on_q <= 1'b0;
			// Timeout is reported once the frame in flight has ended
			if (task_go[T_RXSTOP])
				rxto_pend_q <= 1'b1;
			else if (rx_st_q == RX_IDLE)
				rxto_pend_q <= 1'b0;
			if (task_go[T_FLUSH])
				flush_q <= 1'b1;
			else if (!fifo_out_valid || rx_amt_q == rx_max_q)
				flush_q <= 1'b0;
		end
	end

	// Receive frame engine: start, 8 data bits LSB first, one stop bit
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_ok_q <= 1'b0;
			rx_ferr_q <= 1'b0;
			rx_brk_q <= 1'b0;
		end
		else
		begin
			rx_ok_q <= 1'b0;
			rx_ferr_q <= 1'b0;
			rx_brk_q <= 1'b0;
			rx_cnt_q <= (rx_cnt_q != 16'h0000) ? rx_cnt_q - 16'h0001 : 16'h0000;
			unique case (rx_st_q)
				RX_IDLE:
					if (rx_on_q && !rxd_s2)
					begin
						rx_st_q <= RX_START;
						rx_cnt_q <= HALF_CYC;
					end
				RX_START:
					if (rx_cnt_q == 16'h0000)
					begin
						// A short low pulse is a glitch, not a start bit
						rx_st_q <= rxd_s2 ? RX_IDLE : RX_DATA;
						rx_cnt_q <= BIT_CYC;
						rx_bit_q <= 3'h0;
					end
				RX_DATA:
					if (rx_cnt_q == 16'h0000)
					begin
						rx_sh_q <= {rxd_s2, rx_sh_q[7:1]};
						rx_cnt_q <= BIT_CYC;
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == 3'h7)
							rx_st_q <= RX_STOP;
					end
				RX_STOP:
					if (rx_cnt_q == 16'h0000)
					begin
						rx_ok_q <= rxd_s2;
						rx_ferr_q <= ~rxd_s2;
						rx_st_q <= rxd_s2 ? RX_IDLE : RX_BREAK;
						rx_cnt_q <= BIT_CYC;
					end
				RX_BREAK:
					// One more bit time low makes the line low longer than a whole frame
					if (rxd_s2)
						rx_st_q <= RX_IDLE;
					else if (rx_cnt_q == 16'h0000)
					begin
						rx_brk_q <= 1'b1;
						rx_st_q <= RX_HOLD;
					end
				RX_HOLD:
					if (rxd_s2)
						rx_st_q <= RX_IDLE;
				default:
					rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// Only good bytes enter the FIFO; the drain runs while receiving or flushing
	assign drain_en = (rx_on_q | flush_q) & (rx_amt_q != rx_max_q);
	assign fifo_out_ready = drain_en & (~mem_valid_q | rx_mem_ready);

	uteo_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_D)
	) u_rx_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.in_valid(rx_ok_q),
		.in_ready(fifo_in_ready),
		.in_data(rx_sh_q),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// Memory write stage and request-to-send back-pressure
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			mem_valid_q <= 1'b0;
			mem_data_q <= 8'h00;
			rts_n_q <= 1'b1;
		end
		else
		begin
			if (fifo_out_ready)
			begin
				mem_valid_q <= fifo_out_valid;
				mem_data_q <= fifo_out_data;
			end
			else if (rx_mem_ready)
				mem_valid_q <= 1'b0;
			// Slack covers the frame already on the wire when RTS rises
			rts_n_q <= ~rx_on_q | ~fifo_in_ready
				| (fifo_level >= ($clog2(FIFO_D)+1)'(FIFO_D - RTS_SLACK));
		end
	end

	// Transmitter run state and byte fetch handshake
	assign tx_take = tx_ready_q & tx_mem_valid;

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			tx_on_q <= 1'b0;
			tx_ready_q <= 1'b0;
			tx_amt_q <= 16'h0000;
		end
		else
		begin
			if (task_go[T_TXSTART])
			begin
				tx_on_q <= 1'b1;
				tx_amt_q <= 16'h0000;
			end
			else if (tx_sent_q)
				tx_amt_q <= tx_amt_q + 16'h0001;
			if (task_go[T_TXSTOP] || tx_end_q)
				tx_on_q <= 1'b0;
			tx_ready_q <= (tx_st_q == TX_IDLE) & tx_on_q & ~task_go[T_TXSTOP] & ~cts_s2
				& ~tx_sent_q & (tx_amt_q != tx_max_q) & ~tx_take;
		end
	end

	// Transmit frame engine; a stop lets the frame in flight finish
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			tx_st_q <= TX_IDLE;
			tx_cnt_q <= 16'h0000;
			tx_bit_q <= 3'h0;
			tx_sh_q <= 8'h00;
			txd_q <= 1'b1;
			tx_sent_q <= 1'b0;
			tx_end_q <= 1'b0;
		end
		else
		begin
			tx_sent_q <= 1'b0;
			tx_end_q <= 1'b0;
			tx_cnt_q <= (tx_cnt_q != 16'h0000) ? tx_cnt_q - 16'h0001 : 16'h0000;
			unique case (tx_st_q)
				TX_IDLE:
					if (tx_take)
					begin
						tx_st_q <= TX_START;
						tx_sh_q <= tx_mem_data;
						tx_cnt_q <= BIT_CYC;
						txd_q <= 1'b0;
					end
				TX_START:
					if (tx_cnt_q == 16'h0000)
					begin
						tx_st_q <= TX_DATA;
						tx_cnt_q <= BIT_CYC;
						tx_bit_q <= 3'h0;
						txd_q <= tx_sh_q[0];
					end
				TX_DATA:
					if (tx_cnt_q == 16'h0000)
					begin
						tx_cnt_q <= BIT_CYC;
						tx_bit_q <= tx_bit_q + 3'h1;
						tx_sh_q <= {1'b0, tx_sh_q[7:1]};
						txd_q <= (tx_bit_q == 3'h7) ? 1'b1 : tx_sh_q[1];
						if (tx_bit_q == 3'h7)
							tx_st_q <= TX_STOP;
					end
				TX_STOP:
					if (tx_cnt_q == 16'h0000)
					begin
						tx_st_q <= TX_IDLE;
						tx_sent_q <= 1'b1;
						tx_end_q <= tx_on_q & (tx_amt_q + 16'h0001 == tx_max_q);
					end
			endcase
		end
	end
endmodule : uteo_top

// *** uteo_properties.sv ***
// Port checker for the task, subscription and event block
`timescale 1ns/100ps
module uteo_chk
	import uteo_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cts_n,
	input wire logic txd,
	input wire logic rts_n,
	input wire logic rx_mem_valid,
	input wire logic rx_mem_ready,
	input wire logic [7:0] rx_mem_data,
	input wire logic tx_mem_valid,
	input wire logic tx_mem_ready
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// Steps of one outgoing frame: fetch, then a held start bit
	sequence s_fetch;
		tx_mem_valid && tx_mem_ready;
	endsequence
	sequence s_start;
		!txd [*8];
	endsequence
	// Bus answers: one wait state, one-cycle pulse, quiet data otherwise
	property p_wait;
		$rose(penable) && psel |-> !pready ##1 pready;
	endproperty
	property p_pulse;
		pready |=> !pready;
	endproperty
	property p_rdzero;
		!pready |-> prdata == 32'h0;
	endproperty
	property p_err;
		pslverr |-> pready;
	endproperty
	// Serial lines idle after reset; a fetch starts a frame at once
	property p_idle;
		$past(!resetn) |-> txd && rts_n;
	endproperty
	property p_start;
		s_fetch |=> s_start;
	endproperty
	property p_fetch1;
		s_fetch |=> !tx_mem_ready;
	endproperty
	// Flow control must hold off fetches through the synchroniser
	property p_cts;
		cts_n [*6] |-> !tx_mem_ready;
	endproperty
	// Bytes to memory are never lost while stalled
	property p_hold;
		rx_mem_valid && !rx_mem_ready |=> rx_mem_valid && $stable(rx_mem_data);
	endproperty
	property p_drop;
		$fell(rx_mem_valid) |-> $past(rx_mem_ready);
	endproperty
	a_wait: assert property (p_wait) else $error("pready not after one wait state");
	a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
	a_rdzero: assert property (p_rdzero) else $error("prdata not zero outside answer");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_idle: assert property (p_idle) else $error("lines not idle after reset");
	a_start: assert property (p_start) else $error("no start bit after fetch");
	a_fetch1: assert property (p_fetch1) else $error("second fetch in one frame");
	a_cts: assert property (p_cts) else $error("fetch while not clear to send");
	a_hold: assert property (p_hold) else $error("receive byte changed while stalled");
	a_drop: assert property (p_drop) else $error("receive byte withdrawn unaccepted");
endmodule : uteo_chk

bind uteo_top uteo_chk u_chk (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(cts_n), .txd(txd), .rts_n(rts_n),
	.rx_mem_valid(rx_mem_valid), .rx_mem_ready(rx_mem_ready), .rx_mem_data(rx_mem_data),
	.tx_mem_valid(tx_mem_valid), .tx_mem_ready(tx_mem_ready));

// *** uteo_remote.sv ***
// Remote serial partner: frame sender, frame receiver, clear-to-send driver
`timescale 1ns/100ps
module uteo_remote
	import uteo_pkg::*;
(
	input wire logic ref_clk,
	output logic rxd,
	output logic cts_n,
	input wire logic txd,
	input wire logic rts_n
);
	logic [7:0] rq [$];
	logic [7:0] sh;
	int n_bad;
	// Line idles high, not clear to send until told
	initial
	begin
		rxd = 1'b1;
		cts_n = 1'b1;
		n_bad = 0;
	end
	task set_cts(input logic v);
		cts_n <= v;
	endtask : set_cts
	// One frame, LSB first, only while the device asks for data
	task send(input logic [7:0] b, input int lo_bits);
		while (rts_n !== 1'b0)
			@(posedge ref_clk);
		rxd <= 1'b0;
		repeat (BAUD_DIV) @(posedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			rxd <= b[i];
			repeat (BAUD_DIV) @(posedge ref_clk);
		end
		rxd <= (lo_bits == 0);
		repeat (BAUD_DIV * (lo_bits + 1)) @(posedge ref_clk);
		rxd <= 1'b1;
		repeat (BAUD_DIV * 2) @(posedge ref_clk);
	endtask : send
	// Decode frames from the device mid-bit; a bad stop bit is counted
	always
	begin
		@(negedge txd);
		repeat (HALF_DIV) @(posedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BAUD_DIV) @(posedge ref_clk);
			sh[i] = txd;
		end
		repeat (BAUD_DIV) @(posedge ref_clk);
		if (txd !== 1'b1)
			n_bad++;
		rq.push_back(sh);
	end
endmodule : uteo_remote

// *** test_uteo_top.sv ***
// Self-checking bench for the task, subscription and event block
`timescale 1ns/100ps
module test_uteo_top
	import uteo_pkg::*;
;
	localparam logic [31:0] FF = 32'hffff_ffff;
	logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, rxd, cts_n, txd, rts_n, rx_mem_valid, tx_mem_ready;
	logic [255:0] chan_pulse = '0;
	logic rx_mem_ready = 1'b0, tx_mem_valid = 1'b0;
	logic [7:0] rx_mem_data, tx_mem_data;
	logic [7:0] txb [4] = '{8'h96, 8'h01, 8'h7e, 8'h00};
	logic [7:0] rxq [$];
	int n_fail = 0, compares = 0, nf = 0;
	assign tx_mem_data = txb[nf[1:0]];
	always #20 ref_clk = ~ref_clk;
	uteo_top dut (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chan_pulse(chan_pulse), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n),
		.rx_mem_valid(rx_mem_valid), .rx_mem_ready(rx_mem_ready), .rx_mem_data(rx_mem_data),
		.tx_mem_valid(tx_mem_valid), .tx_mem_ready(tx_mem_ready), .tx_mem_data(tx_mem_data));
	uteo_remote rmt (.ref_clk(ref_clk), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n));
	// Collect bytes handed to memory and count transmit fetches
	always @(posedge ref_clk)
	begin
		if (rx_mem_valid === 1'b1 && rx_mem_ready === 1'b1)
			rxq.push_back(rx_mem_data);
		if (tx_mem_valid === 1'b1 && tx_mem_ready === 1'b1)
			nf <= nf + 1;
	end
	task stop_test();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One bus transfer; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1 && n++ < 100);
		if (n >= 100)
			n_fail++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r & m, x);
	endtask : rd
	// Poll a flag until set, bounded
	task wflag(input logic [11:0] a, input int lim);
		logic [31:0] r;
		logic e;
		int n;
		r = '0;
		n = 0;
		while (r[0] !== 1'b1 && n < lim)
		begin
			apb(1'b0, a, 32'h0, r, e);
			n++;
		end
		chk(r, 32'h1);
	endtask : wflag
	task pulse(input int ch);
		@(posedge ref_clk);
		chan_pulse[ch] <= 1'b1;
		@(posedge ref_clk);
		chan_pulse <= '0;
	endtask : pulse
	// Hang guard, well above the expected length of the run
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		n_fail++;
		stop_test();
	end
	// Main sequence
	initial
	begin
		logic [31:0] r;
		logic e;
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int i = 0; i < N_EVT; i++)
			rd(EVT_OFF[i], FF, 32'h0);
		for (int i = 0; i < N_TASK; i++)
		begin
			rd(SUB_OFF[i], FF, 32'h0);
			wr(SUB_OFF[i], FF);
			rd(SUB_OFF[i], FF, 32'h8000_00ff);
			wr(SUB_OFF[i], 32'h0);
			rd(TASK_OFF[i], FF, 32'h0);
		end
		wr(EVT_OFF[E_RXTO], 32'h1);
		rd(EVT_OFF[E_RXTO], FF, 32'h1);
		wr(EVT_OFF[E_RXTO], 32'h0);
		rd(EVT_OFF[E_RXTO], FF, 32'h0);
		apb(1'b0, 12'h3fc, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
		// Clear-to-send edges both ways
		rmt.set_cts(1'b0);
		wflag(EVT_OFF[E_CTS], 50);
		rmt.set_cts(1'b1);
		wflag(EVT_OFF[E_NCTS], 50);
		rmt.set_cts(1'b0);
		// Receiver started by channel only when the subscription is enabled
		wr(RXMAX_OFF, 32'h8);
		wr(SUB_OFF[T_RXSTART], 32'h5);
		pulse(5);
		rd(STATUS_OFF, 32'h1, 32'h0);
		wr(SUB_OFF[T_RXSTART], 32'h8000_0005);
		pulse(5);
		rd(STATUS_OFF, 32'h1, 32'h1);
		rmt.send(8'ha5, 0);
		wflag(EVT_OFF[E_RXRDY], 50);
		chk(32'(rxq.size()), 32'h0);
		// Bad stop bit then a long low line: framing error, then break
		fork
			rmt.send(8'h0f, 3);
			begin
				wflag(EVT_OFF[E_ERROR], 900);
				wr(EVT_OFF[E_ERROR], 32'h0);
				wflag(EVT_OFF[E_ERROR], 200);
			end
		join
		rmt.send(8'h3c, 0);
		wr(TASK_OFF[T_RXSTOP], 32'h1);
		wflag(EVT_OFF[E_RXTO], 50);
		// Stopped receiver keeps its FIFO until a real flush
		rx_mem_ready <= 1'b1;
		wr(TASK_OFF[T_FLUSH], 32'h0);
		repeat (20) @(posedge ref_clk);
		chk(32'(rxq.size() < 2), 32'h1);
		wr(TASK_OFF[T_FLUSH], 32'h1);
		repeat (20) @(posedge ref_clk);
		chk(32'(rxq.size()), 32'h2);
		chk({16'h0, rxq[0], rxq[1]}, 32'h0000_a53c);
		rd(EVT_OFF[E_ENDRX], FF, 32'h0);
		wr(RXMAX_OFF, 32'h1);
		wr(TASK_OFF[T_RXSTART], 32'h1);
		rmt.send(8'h5a, 0);
		wflag(EVT_OFF[E_ENDRX], 50);
		chk({24'h0, rxq[2]}, 32'h5a);
		// Two-byte transmit buffer, then a stop in mid-buffer
		wr(TXMAX_OFF, 32'h2);
		tx_mem_valid <= 1'b1;
		wr(TASK_OFF[T_TXSTART], 32'h1);
		wflag(EVT_OFF[E_ENDTX], 2000);
		rd(EVT_OFF[E_TXRDY], FF, 32'h1);
		chk({16'h0, rmt.rq[0], rmt.rq[1]}, 32'h0000_9601);
		// Not clear to send: a started transmitter must not fetch
		wr(EVT_OFF[E_NCTS], 32'h0);
		rmt.set_cts(1'b1);
		wr(TXMAX_OFF, 32'h3);
		wr(TASK_OFF[T_TXSTART], 32'h1);
		wflag(EVT_OFF[E_NCTS], 50);
		chk(32'(nf), 32'h2);
		rmt.set_cts(1'b0);
		for (int i = 0; i < 50 && nf < 3; i++)
			@(posedge ref_clk);
		wr(TASK_OFF[T_TXSTOP], 32'h1);
		repeat (5000) @(posedge ref_clk);
		chk(32'(nf), 32'h3);
		chk(32'(rmt.rq.size()), 32'h3);
		rd(STATUS_OFF, 32'h2, 32'h0);
		chk(32'(rmt.n_bad), 32'h0);
		stop_test();
	end
endmodule : test_uteo_top
